// [rcti_map.svh]
// constants for the reciprocal counter and time-interval core
`ifndef RCTI_MAP_SVH
`define RCTI_MAP_SVH

`define RCTI_CLK_PERIOD_NS  5
`define RCTI_CLK_HZ         200_000_000
`define RCTI_NUM_W          72
`define RCTI_RES_W          40
`define RCTI_N_W            32
`define RCTI_TG_W           40
`define RCTI_MT_W           32
`define RCTI_LVL_W          12
`define RCTI_FLOG_W         4
`define RCTI_DUTY_FRAC      16
`define RCTI_FLOG_ONE       4'h0
`define RCTI_FLOG_A_BASE    4'h1
`define RCTI_FLOG_A_ENH     4'h2
`define RCTI_FLOG_HF0_BASE  4'h8
`define RCTI_FLOG_HF0_ENH   4'h9
`define RCTI_FLOG_HF1_BASE  4'h4
`define RCTI_FLOG_HF1_ENH   4'h5
`define RCTI_FLOG_HF2_BASE  4'h5
`define RCTI_FLOG_HF2_ENH   4'h6
`define RCTI_AUTO_LIM_MIN   16'h0001
`define RCTI_AUTO_LIM_MAX   16'hC350
`define RCTI_AUTO_LIM_DEF   16'h0064
`define RCTI_TENTH_MUL      12'h0CD
`define RCTI_TENTH_SHIFT    11

`endif

// [rcti_pkg.sv]
// types of the reciprocal counter and time-interval core
`include "rcti_map.svh"
package rcti_pkg;

    typedef enum logic [3:0] {
        MODE_INPUT_A_FREQUENCY_MODE   = 4'h0,
        MODE_FREQ_B   = 4'h1,
        MODE_FREQ_HF  = 4'h2,
        MODE_BURST    = 4'h3,
        MODE_PERIOD   = 4'h4,
        MODE_TIME_AB  = 4'h5,
        MODE_PWIDTH   = 4'h6,
        MODE_RISEFALL = 4'h7,
        MODE_DUTY     = 4'h8
    } rcti_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ARM  = 3'b001,
        ST_GATE = 3'b011,
        ST_CALC = 3'b010,
        ST_DONE = 3'b110
    } rcti_state_t;

    typedef struct packed {
        rcti_mode_t                 mode;
        logic                       slope_neg;
        logic                       swap;
        logic                       common_input_routing;
        logic                       enhanced_variant;
        logic [1:0]                 hf_band;
        logic                       auto_trigger_en;
        logic [15:0]                auto_trigger_low_freq_limit;
        logic [`RCTI_MT_W-1:0]      meas_time;
    } rcti_cfg_t;

    typedef struct packed {
        logic                       valid;
        logic [`RCTI_RES_W-1:0]     value;
        logic [`RCTI_N_W-1:0]       count;
        logic [`RCTI_TG_W-1:0]      gate_time;
        logic [`RCTI_FLOG_W-1:0]    factor_log;
    } rcti_result_t;

endpackage : rcti_pkg

// [rcti_sync.sv]
// two-stage synchroniser for asynchronous pin levels
module rcti_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset,
    // levels
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stage1 <= '0;
            q      <= '0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule : rcti_sync

// [rcti_prescaler.sv]
// event prescaler with power-of-two division and presence blocking
module rcti_prescaler #(
    parameter int CNT_W = 10
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // events
    input  wire logic       in_event,
    input  wire logic       enable,
    input  wire logic [3:0] factor_log,
    output logic            out_event
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] last;

    initial begin
        if (CNT_W < 10) $error("prescaler counter too narrow for factor 512");
    end

    assign last = CNT_W'((1 << factor_log) - 1);

    // one output per group of d input events, held off without signal
    always_ff @(posedge clk_sys) begin // see [RL1] see [RL7]
        if (reset) begin
            cnt       <= '0;
            out_event <= 1'b0;
        end else if (!enable) begin
            cnt       <= '0;
            out_event <= 1'b0;
        end else begin
            // a factor change can leave cnt above last; wrap at once, not after 2^CNT_W events
            out_event <= in_event && (cnt >= last);
            if (in_event) begin
                cnt <= (cnt >= last) ? '0 : cnt + 1'b1;
            end
        end
    end

    AST_HF_BLOCKED: assert property (@(posedge clk_sys) disable iff (reset) // see [RL7]
        !enable |=> !out_event) else $error("prescaler output while blocked");
    AST_ONE_PER_GROUP: assert property (@(posedge clk_sys) disable iff (reset) // see [RL1]
        out_event && factor_log != 4'h0 |-> !$past(out_event))
        else $error("prescaler output on consecutive events");
endmodule : rcti_prescaler

// [rcti_core.sv]
// reciprocal frequency and time-interval measurement core
// Functional notes
// [RL1] prescaled paths count prescaler output cycles, one per d input cycles
// [RL2] frequency equals count times division factor over measured gate time
// [RL3] high-frequency factor follows fitted band and variant: 256/512, 16/32, 32/64
// [RL4] input A positive slope uses factor 2 or 4; all else factor 1
// [RL5] single-cycle input-A frequency spans two input cycles, four in the enhanced variant
// [RL6] period takes one to nearly two cycles; prescaled frequency twice that
// [RL7] presence detector blocks prescaler output when the signal is absent
// [RL8] a measured burst must outlast factor times input cycle time
// [RL9] channel time starts on A and stops on B; swap exchanges them
// [RL10] common routing feeds input A to start and stop channels
// [RL11] pulse width stops on the opposite slope; swap moves it to B
// [RL12] rise/fall uses A only, forces common routing, B level is 90%
// [RL13] duty runs pulse width then period and outputs their ratio
// [RL14] auto triggering sets level to half the measured amplitude
// [RL15] enhanced variant keeps a 1 Hz..50 kHz auto limit, default 100 Hz
// [RL16] gate opens and closes on first trigger events around measurement time
// [RL17] prescaled single-cycle measurement lasts division-factor input cycles
// [RL18] count and gate-time counters never overflow at maximum settings
`include "rcti_map.svh"
module rcti_core #(
    parameter int N_W  = `RCTI_N_W,
    parameter int TG_W = `RCTI_TG_W
) (
    // clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      reset,
    // comparator pins and presence detector
    input  wire logic                      in_a,
    input  wire logic                      in_b,
    input  wire logic                      in_c,
    input  wire logic                      hf_signal_present,
    // control
    input  wire rcti_pkg::rcti_cfg_t       cfg,
    input  wire logic                      start,
    // amplitude and manual levels
    input  wire logic [`RCTI_LVL_W-1:0]    amp_min,
    input  wire logic [`RCTI_LVL_W-1:0]    amp_max,
    input  wire logic [`RCTI_LVL_W-1:0]    manual_level_a,
    input  wire logic [`RCTI_LVL_W-1:0]    manual_level_b,
    // results and status
    output rcti_pkg::rcti_result_t         result,
    output logic                           busy,
    output logic                           hf_blocked,
    output logic                           auto_trigger_ok,
    // front-end control
    output logic [`RCTI_LVL_W-1:0]         trig_level_a,
    output logic [`RCTI_LVL_W-1:0]         trig_level_b,
    output logic                           common_route_active,
    output logic                           b_controls_disabled
);
    localparam int NUM_W = `RCTI_NUM_W;
    localparam int LW    = `RCTI_LVL_W;

    // widest gate: measurement time plus one slowest prescaled cycle
    initial begin // see [RL18]
        if (TG_W < `RCTI_MT_W + 2) $error("gate-time counter can overflow");
        if (N_W < `RCTI_MT_W) $error("cycle counter can overflow");
        if (N_W + 9 + 28 > NUM_W || TG_W > `RCTI_RES_W) $error("divider too narrow");
    end

    // pins into the clock domain
    logic [3:0] pin_q;
    logic [2:0] pin_prev;

    rcti_sync #(.WIDTH(4)) u_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .d       ({hf_signal_present, in_c, in_b, in_a}),
        .q       (pin_q)
    );

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pin_prev <= '0;
        end else begin
            pin_prev <= pin_q[2:0];
        end
    end

    logic rise_a, fall_a, rise_b, fall_b, rise_c;
    assign rise_a = pin_q[0] && !pin_prev[0];
    assign fall_a = !pin_q[0] && pin_prev[0];
    assign rise_b = pin_q[1] && !pin_prev[1];
    assign fall_b = !pin_q[1] && pin_prev[1];
    assign rise_c = pin_q[2] && !pin_prev[2];

    rcti_pkg::rcti_mode_t mode;
    logic enh, neg;
    assign mode = cfg.mode;
    assign enh  = cfg.enhanced_variant;
    assign neg  = cfg.slope_neg;

    // division factor as a power of two
    logic [3:0] f_log;
    always_comb begin
        f_log = `RCTI_FLOG_ONE;
        case (mode)
            rcti_pkg::MODE_INPUT_A_FREQUENCY_MODE: begin // see [RL4]
                if (!neg) f_log = enh ? `RCTI_FLOG_A_ENH : `RCTI_FLOG_A_BASE;
            end
            rcti_pkg::MODE_FREQ_HF: begin // see [RL3]
                case (cfg.hf_band)
                    2'd0: f_log = enh ? `RCTI_FLOG_HF0_ENH : `RCTI_FLOG_HF0_BASE;
                    2'd1: f_log = enh ? `RCTI_FLOG_HF1_ENH : `RCTI_FLOG_HF1_BASE;
                    default: f_log = enh ? `RCTI_FLOG_HF2_ENH : `RCTI_FLOG_HF2_BASE;
                endcase
            end
            default: f_log = `RCTI_FLOG_ONE;
        endcase
    end

    // counted event stream: hf input gated by presence detector
    logic ev_a, ev_b, psc_in, psc_en, cnt_ev;
    assign ev_a   = neg ? fall_a : rise_a;
    assign ev_b   = neg ? fall_b : rise_b;
    assign psc_in = (mode == rcti_pkg::MODE_FREQ_HF) ? rise_c :
                    (mode == rcti_pkg::MODE_FREQ_B)  ? ev_b : ev_a;
    assign psc_en = (mode != rcti_pkg::MODE_FREQ_HF) || pin_q[3]; // see [RL7]

    // a single cycle on a prescaled path spans d input cycles
    rcti_prescaler #(.CNT_W(10)) u_psc ( // see [RL1] see [RL5] see [RL17]
        .clk_sys   (clk_sys),
        .reset     (reset),
        .in_event  (psc_in),
        .enable    (psc_en),
        .factor_log(f_log),
        .out_event (cnt_ev)
    );

    // start and stop events of the time modes
    logic duty_ph, t_start, t_stop, freq_like;
    always_comb begin
        t_start = 1'b0;
        t_stop  = 1'b0;
        case (mode)
            rcti_pkg::MODE_TIME_AB: begin // see [RL9]
                t_start = cfg.swap ? ev_b : ev_a;
                t_stop  = cfg.swap ? ev_a : ev_b;
            end
            rcti_pkg::MODE_RISEFALL: begin // see [RL12]
                t_start = neg ? fall_b : rise_a;
                t_stop  = neg ? fall_a : rise_b;
            end
            default: begin // see [RL11] see [RL13]
                t_start = cfg.swap ? ev_b : ev_a;
                t_stop  = cfg.swap ? (neg ? rise_b : fall_b) : (neg ? rise_a : fall_a);
                if (duty_ph) t_stop = t_start;
            end
        endcase
    end
    assign freq_like = mode <= rcti_pkg::MODE_PERIOD;

    // gate sequencing
    rcti_pkg::rcti_state_t state;
    logic [`RCTI_MT_W-1:0] timer;
    logic [N_W-1:0]        n_cnt;
    logic [TG_W-1:0]       tg_cnt;
    logic [TG_W-1:0]       pw_time;
    logic                  timer_done, open_ev, close_ev, div_busy;
    assign timer_done = timer >= cfg.meas_time;
    assign open_ev    = freq_like ? cnt_ev : t_start;
    assign close_ev   = freq_like ? (cnt_ev && timer_done) : t_stop;

    always_ff @(posedge clk_sys) begin // see [RL6] see [RL16]
        if (reset) begin
            state   <= rcti_pkg::ST_IDLE;
            timer   <= '0;
            n_cnt   <= '0;
            tg_cnt  <= '0;
            pw_time <= '0;
            duty_ph <= 1'b0;
        end else begin
            if (timer != '1) timer <= timer + 1'b1;
            case (state)
                rcti_pkg::ST_IDLE: begin
                    duty_ph <= 1'b0;
                    if (start) begin
                        timer <= '0;
                        state <= rcti_pkg::ST_ARM;
                    end
                end
                rcti_pkg::ST_ARM: begin
                    if (open_ev) begin
                        n_cnt  <= '0;
                        tg_cnt <= '0;
                        state  <= rcti_pkg::ST_GATE;
                    end
                end
                rcti_pkg::ST_GATE: begin
                    tg_cnt <= tg_cnt + 1'b1;
                    if (cnt_ev) n_cnt <= n_cnt + 1'b1;
                    if (close_ev) begin
                        if (mode == rcti_pkg::MODE_DUTY && !duty_ph) begin // see [RL13]
                            pw_time <= tg_cnt + 1'b1;
                            duty_ph <= 1'b1;
                            timer   <= '0;
                            state   <= rcti_pkg::ST_ARM;
                        end else begin
                            state <= rcti_pkg::ST_CALC;
                        end
                    end
                end
                rcti_pkg::ST_CALC: begin
                    if (!div_busy) state <= rcti_pkg::ST_DONE;
                end
                default: state <= rcti_pkg::ST_IDLE;
            endcase
        end
    end

    // restoring divider for frequency, period and duty
    logic [NUM_W-1:0] div_num;
    logic [TG_W:0]    div_rem;
    logic [TG_W-1:0]  div_den;
    logic [6:0]       div_cnt;
    logic [TG_W:0]    rem_sh;
    logic             div_go;
    assign rem_sh = {div_rem[TG_W-1:0], div_num[NUM_W-1]};
    assign div_go = state == rcti_pkg::ST_GATE && close_ev && !(mode == rcti_pkg::MODE_DUTY && !duty_ph);

    always_ff @(posedge clk_sys) begin // see [RL2]
        if (reset) begin
            div_num  <= '0;
            div_rem  <= '0;
            div_den  <= '0;
            div_cnt  <= '0;
            div_busy <= 1'b0;
        end else if (div_go) begin
            div_rem  <= '0;
            div_cnt  <= 7'(NUM_W);
            div_busy <= freq_like || mode == rcti_pkg::MODE_DUTY;
            if (mode == rcti_pkg::MODE_PERIOD) begin
                div_num <= NUM_W'(tg_cnt + 1'b1);
                div_den <= TG_W'(n_cnt + 1'b1);
            end else if (mode == rcti_pkg::MODE_DUTY) begin
                div_num <= NUM_W'(pw_time) << `RCTI_DUTY_FRAC;
                div_den <= tg_cnt + 1'b1;
            end else if (freq_like) begin
                div_num <= (NUM_W'(n_cnt + 1'b1) << f_log) * NUM_W'(`RCTI_CLK_HZ);
                div_den <= tg_cnt + 1'b1;
            end else begin
                div_num <= NUM_W'(tg_cnt + 1'b1);
                div_den <= '0;
            end
        end else if (div_busy) begin
            div_cnt <= div_cnt - 1'b1;
            if (div_cnt == 7'd1) div_busy <= 1'b0;
            if (rem_sh >= {1'b0, div_den}) begin
                div_rem <= rem_sh - {1'b0, div_den};
                div_num <= {div_num[NUM_W-2:0], 1'b1};
            end else begin
                div_rem <= rem_sh;
                div_num <= {div_num[NUM_W-2:0], 1'b0};
            end
        end
    end

    // result capture and status
    logic [`RCTI_RES_W-1:0] last_freq;
    logic                   capture;
    assign capture = state == rcti_pkg::ST_CALC && !div_busy;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            result    <= '0;
            busy      <= 1'b0;
            last_freq <= '0;
        end else begin
            busy         <= state != rcti_pkg::ST_IDLE && state != rcti_pkg::ST_DONE;
            result.valid <= capture;
            if (state == rcti_pkg::ST_GATE && close_ev) begin
                result.count      <= n_cnt + N_W'(cnt_ev);
                result.gate_time  <= tg_cnt + 1'b1;
                result.factor_log <= f_log;
            end
            if (capture) begin
                // saturate rather than wrap on an oversized quotient
                result.value <= (div_num[NUM_W-1:`RCTI_RES_W] != '0) ? '1 : div_num[`RCTI_RES_W-1:0];
                if (freq_like && mode != rcti_pkg::MODE_PERIOD) last_freq <= div_num[`RCTI_RES_W-1:0];
            end
        end
    end

    // trigger levels; auto levels only while the signal is fast enough
    logic [LW-1:0]  amp, half_lvl, tenth;
    logic [15:0]    lim;
    logic           rf;
    assign rf       = mode == rcti_pkg::MODE_RISEFALL;
    assign amp      = amp_max - amp_min;
    assign half_lvl = amp_min + (amp >> 1);
    assign tenth    = LW'((2 * LW)'(amp) * (2 * LW)'(`RCTI_TENTH_MUL) >> `RCTI_TENTH_SHIFT);
    always_comb begin // see [RL15]
        lim = `RCTI_AUTO_LIM_DEF;
        if (enh) begin
            lim = cfg.auto_trigger_low_freq_limit;
            if (lim < `RCTI_AUTO_LIM_MIN) lim = `RCTI_AUTO_LIM_MIN;
            if (lim > `RCTI_AUTO_LIM_MAX) lim = `RCTI_AUTO_LIM_MAX;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            auto_trigger_ok     <= 1'b0;
            trig_level_a        <= '0;
            trig_level_b        <= '0;
            common_route_active <= 1'b0;
            b_controls_disabled <= 1'b0;
            hf_blocked          <= 1'b0;
        end else begin
            auto_trigger_ok     <= last_freq >= `RCTI_RES_W'(lim); // see [RL15]
            common_route_active <= cfg.common_input_routing || rf; // see [RL10] see [RL12]
            b_controls_disabled <= rf; // see [RL12]
            hf_blocked          <= mode == rcti_pkg::MODE_FREQ_HF && !pin_q[3];
            if (cfg.auto_trigger_en && auto_trigger_ok) begin
                trig_level_a <= rf ? amp_min + tenth : half_lvl; // see [RL14]
                trig_level_b <= rf ? amp_max - tenth : half_lvl;
            end else begin
                trig_level_a <= manual_level_a;
                trig_level_b <= manual_level_b;
            end
        end
    end

    AST_FACTOR_A: assert property (@(posedge clk_sys) disable iff (reset) // see [RL4]
        mode == rcti_pkg::MODE_INPUT_A_FREQUENCY_MODE && !neg |-> f_log == (enh ? 4'h2 : 4'h1))
        else $error("input A factor wrong");
    AST_FACTOR_HF: assert property (@(posedge clk_sys) disable iff (reset) // see [RL3]
        mode == rcti_pkg::MODE_FREQ_HF && cfg.hf_band == 2'd0 |-> f_log == (enh ? 4'h9 : 4'h8))
        else $error("hf lowest band factor wrong");
    AST_GATE_OPEN: assert property (@(posedge clk_sys) disable iff (reset) // see [RL16]
        state == rcti_pkg::ST_ARM && open_ev |=> state == rcti_pkg::ST_GATE && tg_cnt == '0)
        else $error("gate did not open on first event");
    AST_GATE_HOLD: assert property (@(posedge clk_sys) disable iff (reset) // see [RL16]
        state == rcti_pkg::ST_GATE && freq_like && !timer_done |=> state == rcti_pkg::ST_GATE)
        else $error("gate closed before measurement time");
    AST_RF_COMMON: assert property (@(posedge clk_sys) disable iff (reset) // see [RL12]
        rf ##1 rf |-> common_route_active && b_controls_disabled)
        else $error("rise/fall without common routing");
    AST_AUTO_HALF: assert property (@(posedge clk_sys) disable iff (reset) // see [RL14]
        cfg.auto_trigger_en && auto_trigger_ok && !rf |=> trig_level_a == $past(half_lvl))
        else $error("auto level not at half amplitude");
    AST_VALID_PULSE: assert property (@(posedge clk_sys) disable iff (reset) // see [RL2]
        result.valid |=> !result.valid) else $error("result valid longer than a cycle");
endmodule : rcti_core

// [rcti_far_side.sv]
// far-side signal sources for counter inputs a, b and c
module rcti_far_side (
    // clock
    input  wire logic        clk_sys,
    // waveform control
    input  wire logic        run,
    input  wire logic [15:0] period,
    input  wire logic [15:0] high_len,
    input  wire logic [5:0]  b_delay,
    input  wire logic        c_on,
    // pins
    output logic             in_a,
    output logic             in_b,
    output logic             in_c,
    output logic             hf_signal_present
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] phase = 16'h0000;
    logic [63:0] hist  = 64'h0000_0000_0000_0000;
    // b is the same source seen through a later comparator threshold
    assign in_a = hist[0];
    assign in_b = hist[b_delay];
    initial begin
        in_c              = 1'b0;
        hf_signal_present = 1'b0;
    end
    // c never rests: with no carrier the line still chatters
    always @(negedge clk_sys) begin
        phase             <= (!run || phase >= period - 16'h0001) ? 16'h0000 : phase + 16'h0001;
        hist              <= {hist[62:0], run && (phase < high_len)};
        in_c              <= ~in_c;  // steady tone far outlasts factor times cycle
        hf_signal_present <= c_on;
    end
endmodule : rcti_far_side

// [testbench.sv]
// self-checking bench for the measurement core
`include "rcti_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // stimulus
    logic                   clk_sys  = 1'b0;
    logic                   reset    = 1'b1;
    logic                   start    = 1'b0;
    logic                   run      = 1'b0;
    logic                   c_on     = 1'b0;
    logic [15:0]            period   = 16'h0014;
    logic [15:0]            high_len = 16'h000A;
    logic [5:0]             b_delay  = 6'h03;
    rcti_pkg::rcti_cfg_t    cfg      = '0;
    logic [`RCTI_LVL_W-1:0] man_a    = 12'h0AB;
    logic [`RCTI_LVL_W-1:0] man_b    = 12'h0CD;
    // observed
    wire logic              in_a, in_b, in_c, hf_present;
    rcti_pkg::rcti_result_t result;
    logic                   busy, hf_blocked, auto_ok, com_act, b_dis;
    logic [`RCTI_LVL_W-1:0] tla, tlb;
    logic                   got;
    int                     err_count  = 0;
    int                     n_compared = 0;

    always #2.5 clk_sys = ~clk_sys;

    rcti_far_side rcti_far_side_inst (.clk_sys(clk_sys), .run(run), .period(period), .high_len(high_len),
        .b_delay(b_delay), .c_on(c_on), .in_a(in_a), .in_b(in_b), .in_c(in_c), .hf_signal_present(hf_present));

    rcti_core rcti_core_inst (.clk_sys(clk_sys), .reset(reset), .in_a(in_a), .in_b(in_b), .in_c(in_c),
        .hf_signal_present(hf_present), .cfg(cfg), .start(start), .amp_min(12'h100), .amp_max(12'h300),
        .manual_level_a(man_a), .manual_level_b(man_b), .result(result), .busy(busy),
        .hf_blocked(hf_blocked), .auto_trigger_ok(auto_ok), .trig_level_a(tla), .trig_level_b(tlb),
        .common_route_active(com_act), .b_controls_disabled(b_dis));

    task automatic tally_and_finish();
        if (err_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [63:0] seen, input logic [63:0] expected);
        n_compared++;
        if (seen !== expected) begin
            err_count++;
            $display("CHECK FAILED at %0t ns seen %h expected %h", $time, seen, expected);
        end
    endtask : check

    // time figures carry one cycle of edge quantisation
    task automatic near(input logic [63:0] seen, input logic [63:0] expected, input logic [63:0] tol);
        check((seen + tol >= expected) && (seen <= expected + tol), 1'b1);
    endtask : near

    task automatic wait_valid(input int limit);
        got = 1'b0;
        for (int i = 0; i < limit && got == 1'b0; i++) begin
            @(negedge clk_sys);
            got = (result.valid === 1'b1);
        end
    endtask : wait_valid

    task automatic run_meas(input int limit);
        @(negedge clk_sys);
        start = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        wait_valid(limit);
    endtask : run_meas

    task automatic measure();
        run_meas(30000);
        if (got == 1'b0) begin
            err_count++;
            tally_and_finish();
        end
    endtask : measure

    task automatic t_freq();
        logic [3:0] lg [5] = '{4'h1, 4'h2, 4'h0, 4'h0, 4'h0};
        cfg.meas_time = 32'h0000_0190;
        for (int k = 0; k < 5; k++) begin
            cfg.mode             = rcti_pkg::rcti_mode_t'((k == 3) + 3 * (k == 4));
            cfg.enhanced_variant = (k == 1);
            cfg.slope_neg        = (k == 2);
            measure();
            check(result.factor_log, lg[k]);
            check(result.value, 40'h00_0098_9680);  // ten megahertz
            check(result.count * (64'h1 << lg[k]) * 20, result.gate_time);
            @(negedge clk_sys);
            check(auto_ok, 1'b1);  // lags the result by a cycle
        end
    endtask : t_freq

    task automatic t_hf();
        logic [3:0] lg [6] = '{`RCTI_FLOG_HF0_BASE, `RCTI_FLOG_HF0_ENH, `RCTI_FLOG_HF1_BASE,
                               `RCTI_FLOG_HF1_ENH, `RCTI_FLOG_HF2_BASE, `RCTI_FLOG_HF2_ENH};
        cfg.mode      = rcti_pkg::MODE_FREQ_HF;
        cfg.meas_time = 32'h0000_0064;
        cfg.hf_band   = 2'h1;
        run_meas(3000);
        check(got, 1'b0);  // chatter alone yields nothing
        check(hf_blocked, 1'b1);
        check(busy, 1'b1);  // still waiting for a counted event
        c_on = 1'b1;
        wait_valid(30000);
        check(got, 1'b1);
        for (int k = 0; k < 6; k++) begin
            cfg.hf_band          = 2'(k / 2);
            cfg.enhanced_variant = k[0];
            measure();
            check(result.factor_log, lg[k]);
            check(result.value, 40'h00_05F5_E100);  // hundred megahertz
            check(result.count * (64'h1 << lg[k]) * 2, result.gate_time);
        end
    endtask : t_hf

    task automatic t_time();
        int md [7] = '{5, 5, 6, 6, 6, 7, 7};
        int ex [7] = '{17, 183, 50, 150, 50, 17, 183};
        period   = 16'h00C8;
        high_len = 16'h0032;
        b_delay  = 6'h11;
        cfg.common_input_routing = 1'b1;
        for (int k = 0; k < 7; k++) begin
            cfg.mode      = rcti_pkg::rcti_mode_t'(md[k]);
            cfg.swap      = (k == 1 || k == 4);
            cfg.slope_neg = (k == 3 || k == 6);
            measure();
            near(result.value, ex[k], 1);
            check(com_act, k == 0 || md[k] == 7);
            check(b_dis, md[k] == 7);
            if (md[k] == 7) check(tlb, man_b);
            cfg.common_input_routing = 1'b0;
        end
    endtask : t_time

    task automatic t_duty();
        cfg.mode = rcti_pkg::MODE_DUTY;
        for (int k = 0; k < 2; k++) begin
            cfg.slope_neg = k[0];
            measure();
            near(result.value, k ? 40'h00_0000_C000 : 40'h00_0000_4000, 40'h00_0000_0200);
        end
        cfg.mode = rcti_pkg::MODE_PERIOD;
        measure();
        check(result.value, 40'h00_0000_00C8);  // period in clock cycles
        check(result.gate_time, 40'h00_0000_00C8);  // one full input cycle
    endtask : t_duty

    task automatic t_auto();
        cfg.mode = rcti_pkg::MODE_TIME_AB;
        cfg.swap = 1'b0;
        measure();
        check(tla, man_a);
        cfg.auto_trigger_en = 1'b1;
        measure();
        check(tla, 12'h200);  // midway between the peaks
        near(result.value, 17, 1);
        cfg.mode = rcti_pkg::MODE_RISEFALL;
        measure();
        check(tla, 12'h133);  // a tenth above the low peak
        check(tlb, 12'h2CD);  // a tenth below the high peak
        near(result.value, 183, 1);  // fall: b falling edge to a falling edge
    endtask : t_auto

    initial begin
        cfg.auto_trigger_low_freq_limit = 16'h0064;
        repeat (6) @(negedge clk_sys);
        reset = 1'b0;
        check({busy, hf_blocked, auto_ok, result.valid}, 4'h0);
        run = 1'b1;
        t_freq();
        t_hf();
        t_time();
        t_duty();
        t_auto();
        tally_and_finish();
    end
endmodule : testbench
